// ---- logic/fast_ethernet_pcs.sv ----
`timescale 1ns/10ps
`default_nettype none

module fast_ethernet_pcs #(
  parameter int IDLE_WINDOW = pcs_pkg::IDLE_WINDOW_BITS
) (
  input  wire logic           clk,
  input  wire logic           arst_n,
  input  wire logic [4:0]     transceiverAddress,
  input  wire logic           txEn,
  input  wire logic           txErr,
  input  wire pcs_pkg::nib_t  txData,
  output logic                txTake,
  output logic                txNrzi,
  output pcs_pkg::lvl_t       txLevel,
  input  wire logic           rxClk,
  input  wire logic [5:0]     rxSample,
  output pcs_pkg::nib_t       rxData,
  output logic                rxDv,
  output logic                rxErr,
  output logic                rxStrobe,
  output logic                crs,
  output logic                rxSynced
);
  import pcs_pkg::*;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SSD  = 2'b01,
    TX_DATA = 2'b10,
    TX_ESD  = 2'b11
  } txState_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SSD  = 2'b01,
    RX_DATA = 2'b10,
    RX_ESD  = 2'b11
  } rxState_t;

  // Transmit side
  txState_t    txState_ff;
  txState_t    nxt_txState;
  logic [4:0]  addrS1_ff;
  logic [4:0]  addrS2_ff;
  logic [1:0]  warm_ff;
  logic [2:0]  bitCnt_ff;
  grp_t        txSh_ff;
  grp_t        nxt_txSh;
  logic [10:0] txKey_ff;
  logic        nrzi_ff;
  logic [1:0]  mltPh_ff;
  lvl_t        txLevel_ff;
  logic        grpEnd;
  logic        keyFb;
  logic        scrBit;
  logic [1:0]  nxt_mltPh;
  lvl_t        nxt_level;
  grp_t        dataGroup;

  assign grpEnd    = bitCnt_ff == 3'(GROUP_BITS - 1);
  assign keyFb     = txKey_ff[10] ^ txKey_ff[8];
  assign scrBit    = txSh_ff[4] ^ keyFb;
  assign dataGroup = txErr ? CG_H : encGroup(txData);
  assign nxt_mltPh = mltPh_ff + {1'b0, scrBit};
  // Phase walk 0, +, 0, - gives the three-level cycle
  assign nxt_level = !nxt_mltPh[0] ? LVL_ZERO :
                     nxt_mltPh[1]  ? LVL_NEG  : LVL_POS;
  // Take is combinational so the MAC sees it inside its slot
  assign txTake    = grpEnd;
  assign txNrzi    = nrzi_ff;
  assign txLevel   = txLevel_ff;

  always_comb begin
    nxt_txState = txState_ff;
    nxt_txSh    = CG_IDLE;
    case (txState_ff)
      TX_IDLE: begin
        if (txEn) begin
          nxt_txSh    = CG_J;
          nxt_txState = TX_SSD;
        end
      end
      TX_SSD: begin
        // Preamble nibbles at the J and K takes are dropped
        nxt_txSh    = CG_K;
        nxt_txState = TX_DATA;
      end
      TX_DATA: begin
        if (txEn) begin
          nxt_txSh = dataGroup;
        end else begin
          nxt_txSh    = CG_T;
          nxt_txState = TX_ESD;
        end
      end
      TX_ESD: begin
        nxt_txSh    = CG_R;
        nxt_txState = TX_IDLE;
      end
      default: begin
        nxt_txState = TX_IDLE;
      end
    endcase
  end

  // Address is a strap; it is settled before the seed is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addrS1_ff <= '0;
      addrS2_ff <= '0;
      warm_ff   <= '0;
    end else begin
      addrS1_ff <= transceiverAddress;
      addrS2_ff <= addrS1_ff;
      if (warm_ff != WARM_DONE) begin
        warm_ff <= warm_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txKey_ff <= 11'h7ff;
    end else if (warm_ff != WARM_DONE) begin
      // Seed is taken once; a new address needs a reset
      txKey_ff <= seedOf(addrS2_ff);
    end else begin
      txKey_ff <= {txKey_ff[9:0], keyFb};
    end
  end

  // One code bit per clock edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txState_ff <= TX_IDLE;
      txSh_ff    <= CG_IDLE;
      bitCnt_ff  <= '0;
    end else if (grpEnd) begin
      txState_ff <= nxt_txState;
      txSh_ff    <= nxt_txSh;
      bitCnt_ff  <= '0;
    end else begin
      txSh_ff    <= {txSh_ff[3:0], 1'b0};
      bitCnt_ff  <= bitCnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nrzi_ff    <= 1'b0;
      mltPh_ff   <= '0;
      txLevel_ff <= LVL_ZERO;
    end else begin
      nrzi_ff    <= nrzi_ff ^ scrBit;
      mltPh_ff   <= nxt_mltPh;
      txLevel_ff <= nxt_level;
    end
  end

  // Receive side
  // Link logic runs on the recovered receive clock
  rx_group_if rxLink ();

  pcs_rx_front #(
    .IDLE_WINDOW (IDLE_WINDOW)
  ) rxFront (
    .rxClk    (rxClk),
    .arst_n   (arst_n),
    .rxSample (rxSample),
    .link     (rxLink.link)
  );

  rxState_t   rxState_ff;
  rxState_t   nxt_rxState;
  logic       tglS1_ff;
  logic       tglS2_ff;
  logic       tglS3_ff;
  logic       lockS1_ff;
  logic       lockS2_ff;
  nib_t       rxData_ff;
  nib_t       nxt_rxData;
  logic       rxDv_ff;
  logic       nxt_rxDv;
  logic       rxErr_ff;
  logic       nxt_rxErr;
  logic       rxStrobe_ff;
  logic       nxt_rxStrobe;
  logic       crs_ff;
  logic       nxt_crs;
  logic       dupPre_ff;
  logic       nxt_dupPre;
  logic       idleOne_ff;
  logic       nxt_idleOne;
  logic       frameEnd;
  logic       grpEvt;
  logic [4:0] rxDec;
  logic       rxIsData;
  grp_t       rxGrp;
  logic       rxIsJ;
  logic       rxIsK;
  logic       rxIsEnd;
  logic       rxIsTail;
  logic       rxIsIdle;

  // Group word is held five link clocks, well past the toggle sync;
  // this limits the link clock to about five thirds of the core rate
  assign grpEvt   = tglS2_ff ^ tglS3_ff;
  assign rxGrp    = rxLink.grp;
  assign rxDec    = decGroup(rxGrp);
  assign rxIsData = rxDec[4];
  assign rxIsJ    = rxGrp == CG_J;
  assign rxIsK    = rxGrp == CG_K;
  assign rxIsEnd  = rxGrp == CG_T;
  assign rxIsTail = rxGrp == CG_R;
  assign rxIsIdle = rxGrp == CG_IDLE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tglS1_ff  <= 1'b0;
      tglS2_ff  <= 1'b0;
      tglS3_ff  <= 1'b0;
      lockS1_ff <= 1'b0;
      lockS2_ff <= 1'b0;
    end else begin
      tglS1_ff  <= rxLink.evtTgl;
      tglS2_ff  <= tglS1_ff;
      tglS3_ff  <= tglS2_ff;
      // Lock is a slow level, two flops suffice
      lockS1_ff <= rxLink.locked;
      lockS2_ff <= lockS1_ff;
    end
  end

  always_comb begin
    nxt_rxState  = rxState_ff;
    nxt_rxData   = rxData_ff;
    nxt_rxDv     = rxDv_ff;
    nxt_crs      = crs_ff;
    nxt_rxErr    = 1'b0;
    nxt_rxStrobe = 1'b0;
    nxt_dupPre   = 1'b0;
    nxt_idleOne  = idleOne_ff;
    frameEnd     = 1'b0;
    // Second preamble nibble one cycle after the first
    if (dupPre_ff) begin
      nxt_rxStrobe = 1'b1;
      nxt_rxData   = NIB_PRE;
    end
    if (!lockS2_ff) begin
      frameEnd = 1'b1;
    end else if (grpEvt) begin
      case (rxState_ff)
        RX_IDLE: begin
          if (rxIsJ) begin
            nxt_rxState = RX_SSD;
            nxt_crs     = 1'b1;
          end
        end
        RX_SSD: begin
          nxt_rxStrobe = 1'b1;
          if (rxIsK) begin
            nxt_rxState = RX_DATA;
            nxt_rxDv    = 1'b1;
            nxt_rxData  = NIB_PRE;
            nxt_dupPre  = 1'b1;
          end else begin
            // No data valid yet, so the MAC sees only the error
            nxt_rxErr  = 1'b1;
            nxt_rxData = NIB_BAD_SSD;
            frameEnd   = 1'b1;
          end
        end
        RX_DATA: begin
          if (rxIsData) begin
            nxt_rxStrobe = 1'b1;
            nxt_rxData   = rxDec[3:0];
            nxt_idleOne  = 1'b0;
          end else if (rxIsEnd) begin
            nxt_rxState = RX_ESD;
          end else if (rxIsIdle) begin
            // A lone idle is tolerated; the second one ends the frame
            frameEnd    = idleOne_ff;
            nxt_idleOne = 1'b1;
          end else begin
            // Data nibble is left as it was
            nxt_rxStrobe = 1'b1;
            nxt_rxErr    = 1'b1;
          end
        end
        RX_ESD: begin
          // T must be followed by R; anything else is an error
          if (!rxIsTail) begin
            nxt_rxStrobe = 1'b1;
            nxt_rxErr    = 1'b1;
          end
          frameEnd = 1'b1;
        end
        default: begin
          frameEnd = 1'b1;
        end
      endcase
    end
    // Carrier and data valid fall together, except after a bad start pair, where carrier falls alone
    if (frameEnd) begin
      nxt_rxState = RX_IDLE;
      nxt_rxDv    = 1'b0;
      nxt_crs     = 1'b0;
      nxt_idleOne = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxState_ff  <= RX_IDLE;
      rxData_ff   <= '0;
      rxDv_ff     <= 1'b0;
      rxErr_ff    <= 1'b0;
      rxStrobe_ff <= 1'b0;
      crs_ff      <= 1'b0;
      dupPre_ff   <= 1'b0;
      idleOne_ff  <= 1'b0;
    end else begin
      rxState_ff  <= nxt_rxState;
      rxData_ff   <= nxt_rxData;
      rxDv_ff     <= nxt_rxDv;
      rxErr_ff    <= nxt_rxErr;
      rxStrobe_ff <= nxt_rxStrobe;
      crs_ff      <= nxt_crs;
      dupPre_ff   <= nxt_dupPre;
      idleOne_ff  <= nxt_idleOne;
    end
  end

  assign rxData   = rxData_ff;
  assign rxDv     = rxDv_ff;
  assign rxErr    = rxErr_ff;
  assign rxStrobe = rxStrobe_ff;
  assign crs      = crs_ff;
  assign rxSynced = lockS2_ff;

endmodule : fast_ethernet_pcs

`default_nettype wire

// ---- shared/pcs_pkg.sv ----
package pcs_pkg;

  typedef logic [3:0] nib_t;
  typedef logic [4:0] grp_t;
  typedef logic [1:0] lvl_t;

  localparam grp_t CG_IDLE = 5'h1f;
  localparam grp_t CG_J    = 5'h18;
  localparam grp_t CG_K    = 5'h11;
  localparam grp_t CG_T    = 5'h0d;
  localparam grp_t CG_R    = 5'h07;
  localparam grp_t CG_H    = 5'h04;

  localparam nib_t NIB_PRE     = 4'h5;
  localparam nib_t NIB_BAD_SSD = 4'he;

  localparam lvl_t LVL_ZERO = 2'h0;
  localparam lvl_t LVL_POS  = 2'h1;
  localparam lvl_t LVL_NEG  = 2'h3;

  localparam int GROUP_BITS       = 5;
  localparam int BIT_RATE_MHZ     = 125;
  localparam int IDLE_WINDOW_US   = 40;
  localparam int IDLE_WINDOW_BITS = IDLE_WINDOW_US * BIT_RATE_MHZ;
  localparam int SYNC_BITS        = 30;

  localparam logic [4:0]        SEED_MIX = 5'h15;
  localparam logic [5:0]        SEED_LOW = 6'h2b;
  localparam logic signed [5:0] SLICE_TH = 6'sh0c;
  localparam logic [1:0]        WARM_DONE = 2'h3;

  localparam grp_t ENC_TAB [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
  };

  function automatic grp_t encGroup(input nib_t n);
    return ENC_TAB[n];
  endfunction : encGroup

  // Returns {is data, nibble}
  function automatic logic [4:0] decGroup(input grp_t g);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (ENC_TAB[i] == g) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : decGroup

  // Low bits fixed nonzero so no address locks the sequence at zero
  function automatic logic [10:0] seedOf(input logic [4:0] addr);
    return {addr ^ SEED_MIX, SEED_LOW};
  endfunction : seedOf

endpackage : pcs_pkg

// ---- shared/rx_group_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface rx_group_if;
  logic [4:0] grp;
  logic       evtTgl;
  logic       locked;
  modport link (output grp, output evtTgl, output locked);
  modport core (input grp, input evtTgl, input locked);
endinterface : rx_group_if

`default_nettype wire

// ---- logic/pcs_rx_front.sv ----
`timescale 1ns/10ps
`default_nettype none

module pcs_rx_front #(
  parameter int IDLE_WINDOW = pcs_pkg::IDLE_WINDOW_BITS
) (
  input  wire logic       rxClk,
  input  wire logic       arst_n,
  input  wire logic [5:0] rxSample,
  rx_group_if.link        link
);
  import pcs_pkg::*;

  localparam int WDW = $clog2(IDLE_WINDOW);

  lvl_t           level_ff;
  logic           nrzi_ff;
  logic           nrziPrev_ff;
  logic [10:0]    key_ff;
  logic [4:0]     syncCnt_ff;
  logic           locked_ff;
  logic [9:0]     sh_ff;
  logic [WDW-1:0] wdCnt_ff;
  logic           inFrame_ff;
  logic [2:0]     bitPh_ff;
  grp_t           prevGrp_ff;
  grp_t           grp_ff;
  logic           tgl_ff;

  lvl_t           sliced;
  logic           codeBit;
  logic           keyFb;
  logic           keyHit;
  logic           plain;
  logic           idleSeen;
  logic           wdExpire;
  logic           syncDone;
  logic           jHit;
  logic           grpDone;
  logic           grpEnds;
  logic [9:0]     nxt_sh;
  grp_t           newGrp;

  // Signed sample; the slicer stands in for the DSP level decision
  assign sliced   = ($signed(rxSample) > SLICE_TH)  ? LVL_POS :
                    ($signed(rxSample) < -SLICE_TH) ? LVL_NEG :
                    LVL_ZERO;
  assign codeBit  = nrzi_ff ^ nrziPrev_ff;
  assign keyFb    = key_ff[10] ^ key_ff[8];
  // Idle is all ones in clear, so the line bit is the inverted key
  assign keyHit   = keyFb == ~codeBit;
  assign plain    = codeBit ^ keyFb;
  assign nxt_sh   = {sh_ff[8:0], plain};
  assign idleSeen = &sh_ff;
  assign wdExpire = locked_ff && wdCnt_ff == WDW'(IDLE_WINDOW - 1);
  assign syncDone = keyHit && syncCnt_ff == 5'(SYNC_BITS - 1);
  assign jHit     = locked_ff && !inFrame_ff && nxt_sh == {CG_IDLE, CG_J};
  assign grpDone  = inFrame_ff && bitPh_ff == 3'(GROUP_BITS - 1);
  assign newGrp   = nxt_sh[4:0];
  assign grpEnds  = newGrp == CG_R ||
                    (newGrp == CG_IDLE && prevGrp_ff == CG_IDLE) ||
                    (prevGrp_ff == CG_J && newGrp != CG_K);

  always_ff @(posedge rxClk or negedge arst_n) begin
    if (!arst_n) begin
      level_ff    <= LVL_ZERO;
      nrzi_ff     <= 1'b0;
      nrziPrev_ff <= 1'b0;
    end else begin
      level_ff    <= sliced;
      nrzi_ff     <= nrzi_ff ^ (sliced != level_ff);
      nrziPrev_ff <= nrzi_ff;
    end
  end

  always_ff @(posedge rxClk or negedge arst_n) begin
    if (!arst_n) begin
      key_ff     <= 11'h7ff;
      syncCnt_ff <= '0;
      locked_ff  <= 1'b0;
      wdCnt_ff   <= '0;
    end else if (!locked_ff) begin
      key_ff     <= {key_ff[9:0], ~codeBit};
      syncCnt_ff <= keyHit ? syncCnt_ff + 5'h01 : 5'h00;
      locked_ff  <= syncDone;
      wdCnt_ff   <= '0;
    end else begin
      key_ff     <= {key_ff[9:0], keyFb};
      syncCnt_ff <= '0;
      locked_ff  <= !wdExpire;
      wdCnt_ff   <= idleSeen ? '0 : wdCnt_ff + 1'b1;
    end
  end

  // Alignment is fixed at J and kept until the frame ends
  always_ff @(posedge rxClk or negedge arst_n) begin
    if (!arst_n) begin
      sh_ff      <= '0;
      inFrame_ff <= 1'b0;
      bitPh_ff   <= '0;
      prevGrp_ff <= CG_IDLE;
      grp_ff     <= CG_IDLE;
      tgl_ff     <= 1'b0;
    end else begin
      sh_ff <= nxt_sh;
      if (!locked_ff) begin
        inFrame_ff <= 1'b0;
      end else if (jHit) begin
        inFrame_ff <= 1'b1;
        bitPh_ff   <= '0;
        prevGrp_ff <= CG_J;
        grp_ff     <= CG_J;
        tgl_ff     <= ~tgl_ff;
      end else if (inFrame_ff) begin
        bitPh_ff <= grpDone ? 3'h0 : bitPh_ff + 3'h1;
        if (grpDone) begin
          prevGrp_ff <= newGrp;
          grp_ff     <= newGrp;
          tgl_ff     <= ~tgl_ff;
          inFrame_ff <= !grpEnds;
        end
      end
    end
  end

  assign link.grp    = grp_ff;
  assign link.evtTgl = tgl_ff;
  assign link.locked = locked_ff;

endmodule : pcs_rx_front

`default_nettype wire

// ---- sim/pcs_properties.sv ----
`timescale 1ns/10ps
`default_nettype none

module pcs_properties (
  input wire logic          clk,
  input wire logic          arst_n,
  input wire logic          txTake,
  input wire logic          txNrzi,
  input wire pcs_pkg::lvl_t txLevel,
  input wire pcs_pkg::nib_t rxData,
  input wire logic          rxDv,
  input wire logic          rxErr,
  input wire logic          rxStrobe,
  input wire logic          crs
);
  import pcs_pkg::*;

  lvl_t lastNz_ff;
  lvl_t nxt_lastNz;

  // Last nonzero level fixes which way a step out of zero must go
  assign nxt_lastNz = (txLevel != LVL_ZERO) ? txLevel : lastNz_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      lastNz_ff <= LVL_ZERO;
    else
      lastNz_ff <= nxt_lastNz;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  AST_TAKE_PERIOD: assert property (txTake |=> !txTake [*4] ##1 txTake)
    else $error("take not every fifth cycle");
  AST_MLT_STEP: assert property ($changed(txNrzi) |-> $changed(txLevel))
    else $error("level held on a one bit");
  AST_MLT_HOLD: assert property ($stable(txNrzi) |-> $stable(txLevel))
    else $error("level moved on a zero bit");
  AST_MLT_ORDER: assert property ($changed(txLevel) |-> txLevel != 2'h2
    && ($past(txLevel) == LVL_ZERO || txLevel == LVL_ZERO))
    else $error("level skipped zero");
  AST_MLT_ALT: assert property ($past(txLevel) == LVL_ZERO
    && txLevel != LVL_ZERO && lastNz_ff != LVL_ZERO |-> txLevel != lastNz_ff)
    else $error("level repeated its polarity");
  AST_ERR_STROBE: assert property (rxErr |-> rxStrobe)
    else $error("receive error without strobe");
  AST_DV_CRS: assert property (rxDv |-> crs)
    else $error("data valid without carrier");
  AST_SSD_PAIR: assert property ($rose(rxDv) |-> rxStrobe
    && rxData == NIB_PRE ##1 rxStrobe && rxDv && rxData == NIB_PRE)
    else $error("start pair not two preamble nibbles");
  AST_BAD_SSD: assert property (rxErr && !rxDv && !$past(rxDv)
    |-> rxData == NIB_BAD_SSD ##1 !rxDv)
    else $error("bad start pair nibble wrong");
  AST_DV_DROP: assert property ($fell(rxDv) |-> !crs)
    else $error("carrier held after data valid fell");
endmodule : pcs_properties

bind fast_ethernet_pcs pcs_properties chk (
  .clk(clk), .arst_n(arst_n), .txTake(txTake), .txNrzi(txNrzi),
  .txLevel(txLevel), .rxData(rxData), .rxDv(rxDv), .rxErr(rxErr),
  .rxStrobe(rxStrobe), .crs(crs)
);

`default_nettype wire

// ---- sim/line_partner.sv ----
`timescale 1ns/10ps
`default_nettype none

module line_partner (
  input wire logic       rxClk,
  output var logic [5:0] rxSample
);
  logic [4:0]  q[$];
  logic [4:0]  grp = 5'h1f;
  logic [10:0] key = 11'h5a3;
  logic [1:0]  ph = 2'h0;
  int          left = 0;

  initial rxSample = 6'h00;

  // Phase runs zero, plus, zero, minus; samples sit well past threshold
  always @(posedge rxClk) begin : drive
    logic b;
    if (left == 0) begin
      grp = (q.size() != 0) ? q.pop_front() : 5'h1f;
      left = 5;
    end
    left--;
    b = grp[left] ^ key[10] ^ key[8];
    key = {key[9:0], key[10] ^ key[8]};
    ph = ph + {1'b0, b};
    #1;
    rxSample = !ph[0] ? 6'h00 : (ph[1] ? 6'h2c : 6'h14);
  end
endmodule : line_partner

`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb;
  import pcs_pkg::*;

  localparam int IW = 200;
  localparam grp_t TAB [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam grp_t BADG [10] = '{5'h06, 5'h19, 5'h00, 5'h01, 5'h02, 5'h03,
    5'h05, 5'h08, 5'h0c, 5'h10};

  logic        clk = 1'b0;
  logic        rxClk = 1'b0;
  logic        arst_n = 1'b0;
  logic [4:0]  addr = 5'h0a;
  logic        txEn = 1'b0;
  logic        txErr = 1'b0;
  nib_t        txData = 4'h0;
  logic        txTake, txNrzi, rxDv, rxErr, rxStrobe, crs, rxSynced;
  lvl_t        txLevel;
  nib_t        rxData;
  logic [5:0]  rxSample;
  logic [10:0] key = 11'h000;
  logic [9:0]  sh = 10'h000;
  logic        prevN = 1'b0;
  logic        inFrm = 1'b0;
  int          syn = 0;
  int          cnt = 0;
  int          zeros = 0;
  int          bad_count = 0;
  int          check_count = 0;
  grp_t        txQ[$];
  logic [5:0]  rxQ[$];

  always #10 clk = ~clk;
  // Odd offset keeps link edges off the core edges
  initial begin
    #3;
    forever #80 rxClk = ~rxClk;
  end

  fast_ethernet_pcs #(.IDLE_WINDOW(IW)) uut (
    .clk(clk), .arst_n(arst_n), .transceiverAddress(addr), .txEn(txEn),
    .txErr(txErr), .txData(txData), .txTake(txTake), .txNrzi(txNrzi),
    .txLevel(txLevel), .rxClk(rxClk), .rxSample(rxSample), .rxData(rxData),
    .rxDv(rxDv), .rxErr(rxErr), .rxStrobe(rxStrobe), .crs(crs),
    .rxSynced(rxSynced)
  );
  line_partner far (.rxClk(rxClk), .rxSample(rxSample));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [5:0] e,
                     input logic [5:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Locks on idle itself, so it needs no knowledge of the seed
  always @(posedge clk) begin : txMon
    logic s;
    logic f;
    s = txNrzi ^ prevN;
    prevN = txNrzi;
    f = (syn < 40) ? ~s : key[10] ^ key[8];
    key = {key[9:0], f};
    if (!arst_n)
      syn = 0;
    else if (syn < 40)
      syn++;
    else begin
      sh = {sh[8:0], s ^ f};
      if (!inFrm && !sh[0])
        zeros++;
      if (inFrm && ++cnt == 5) begin
        txQ.push_back(sh[4:0]);
        cnt = 0;
        inFrm = (sh[4:0] != CG_R);
      end
      if (!inFrm && sh == 10'h3f8) begin
        txQ.push_back(CG_J);
        inFrm = 1'b1;
        cnt = 0;
      end
    end
  end

  always @(posedge clk)
    if (rxStrobe === 1'b1)
      rxQ.push_back({rxDv, rxErr, rxData});

  task automatic putNib(input logic en, input logic er, input nib_t d);
    @(posedge clk);
    #1;
    while (txTake !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    txEn = en;
    txErr = er;
    txData = d;
  endtask : putNib

  // Same idle stream under two addresses must scramble differently
  task automatic seedCheck();
    logic [23:0] w[2];
    for (int k = 0; k < 2; k++) begin
      #1;
      arst_n = 1'b0;
      addr = (k == 0) ? 5'h0a : 5'h15;
      // Four link cycles, the slow side needs two edges in reset
      repeat (4) @(posedge rxClk);
      @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (24) begin
        @(posedge clk);
        w[k] = {w[k][22:0], txNrzi};
      end
    end
    chk("seedDiffers", 6'h01, {5'h00, w[0] != w[1]});
  endtask : seedCheck

  task automatic txFrame();
    grp_t ex[$];
    ex = {CG_J, CG_K};
    repeat (100) @(posedge clk);
    repeat (2) putNib(1'b1, 1'b0, 4'h5);
    for (int i = 0; i < 16; i++) begin
      putNib(1'b1, 1'b0, 4'(i));
      ex.push_back(TAB[i]);
    end
    putNib(1'b1, 1'b1, 4'h9);
    putNib(1'b0, 1'b0, 4'h0);
    ex = {ex, CG_H, CG_T, CG_R};
    repeat (60) @(posedge clk);
    chk("txCount", 6'(ex.size()), 6'(txQ.size()));
    foreach (ex[i])
      chk("txGroup", {1'b0, ex[i]}, {1'b0, txQ[i]});
    chk("idleZeros", 6'h03, 6'(zeros));
  endtask : txFrame

  task automatic rxRun(input grp_t g[$], input logic [5:0] e[$]);
    rxQ = {};
    far.q = g;
    while (far.q.size() != 0)
      @(posedge rxClk);
    repeat (30) @(posedge rxClk);
    chk("rxCount", 6'(e.size()), 6'(rxQ.size()));
    foreach (e[i])
      chk("rxNibble", e[i], rxQ[i]);
    chk("rxDvCrs", 6'h00, {4'h0, rxDv, crs});
  endtask : rxRun

  task automatic rxFrames();
    grp_t       g[$];
    logic [5:0] e[$];
    g = {CG_J, CG_K};
    e = {6'h25, 6'h25};
    for (int i = 0; i < 16; i++) begin
      g.push_back(TAB[i]);
      e.push_back(6'h20 | 6'(i));
    end
    g = {g, CG_T, CG_R};
    rxRun(g, e);
    g = {CG_J, CG_K, TAB[3]};
    e = {6'h25, 6'h25, 6'h23};
    rxRun(g, e);
    e = {6'h25, 6'h25, 6'h35};
    foreach (BADG[i]) begin
      g = {CG_J, CG_K, BADG[i], CG_T, CG_R};
      rxRun(g, e);
    end
    g = {CG_J, CG_K, CG_H, CG_T, 5'h00};
    e = {6'h25, 6'h25, 6'h35, 6'h15};
    rxRun(g, e);
    g = {CG_J, 5'h00};
    e = {6'h1e};
    rxRun(g, e);
  endtask : rxFrames

  task automatic rxLockLoss();
    int n;
    n = 0;
    far.q = {CG_J, CG_K};
    repeat (60) far.q.push_back(TAB[0]);
    while (far.q.size() != 0) begin
      @(posedge clk);
      if (rxSynced === 1'b0)
        n++;
    end
    chk("lockDropped", 6'h01, {5'h00, n > 0});
    repeat (400) @(posedge rxClk);
    chk("relocked", 6'h01, {5'h00, rxSynced});
  endtask : rxLockLoss

  initial begin
    seedCheck();
    txFrame();
    while (rxSynced !== 1'b1)
      @(posedge clk);
    rxFrames();
    rxLockLoss();
    conclude();
  end

  initial begin
    #1_000_000;
    bad_count++;
    conclude();
  end
endmodule : tb

`default_nettype wire
